// ### dca_pkg.sv
package dca_pkg;

   // Address multiplexer and refresh counter
   localparam int          DCA_ADDR_W        = 8;
   localparam logic [7:0]  DCA_REFR_ADDR_RST = 8'h00;

   // Refresh interval, nanoseconds and 50 MHz cycles (longest time rounds down)
   localparam int          DCA_CLK_PERIOD_NS = 20;
   localparam int          DCA_REFR_PERIOD_NS = 15600;
   localparam int          DCA_REFR_CYCLES   = DCA_REFR_PERIOD_NS / DCA_CLK_PERIOD_NS;

   // Cycle timing generator steps (travelling-ones position)
   localparam int          DCA_CYC_LEN       = 8;
   localparam int          DCA_RAS_ON        = 0;
   localparam int          DCA_CAS_ON        = 2;
   localparam int          DCA_EARLY_SYS_ACK_N_NORMAL   = 2;
   localparam int          DCA_EARLY_SYS_ACK_N_DELAYED  = 5;
   localparam int          DCA_LATE_XFER_ACK_N_STEP     = 6;
   localparam int          DCA_REFR_LEN      = 6;

   // Multiplexer sources
   typedef enum logic [2:0]
   {
      DCA_MUX_ROW  = 3'b001,
      DCA_MUX_COL  = 3'b010,
      DCA_MUX_REFR = 3'b100
   } dca_mux_type;

   // Arbiter states
   typedef enum logic [2:0]
   {
      DCA_IDLE = 3'b001,
      DCA_MEM  = 3'b010,
      DCA_REF  = 3'b100
   } dca_state_type;

   // Host command group
   typedef struct packed
   {
      logic rd_n;
      logic wr_n;
      logic port_chip_sel_n;
      logic addr_latch_n;
      logic read_status_bit;
   } dca_cmd_type;

   // RAM strobe group
   typedef struct packed
   {
      logic [3:0] ras_n;
      logic       cas_n;
      logic       we_n;
   } dca_ram_type;

endpackage

// ### dca_ctrl.sv
// Summary of operation
// - Two acknowledges, early and late, both mean the access may complete.
// - Late acknowledge after column strobe starts; RAM strobes stay active for its first two cycles.
// - Early acknowledge comes earlier in the cycle than the late one.
// - Acknowledges hold until host withdraws read or write command.
// - Advanced read mode: latch strobe also drops both acknowledges.
// - Level request during refresh waits and gets delayed early acknowledge; an advanced-mode read strobe during refresh is lost.
// - Read or write during refresh sets delayed flag, chip select ignored.
// - Flag set means next memory cycle uses delayed early acknowledge.
// - Flag clears at end of the memory cycle that used it.
// - Advanced read: status high at latch strobe fall during refresh sets flag.
// - Density select high is 16K mode, low is 64K mode.
// - 16K mode: four row strobes and two bank-select inputs as before.
// - 64K mode: bank-2 row strobe pin carries address MSB.
// - 64K mode: bank-select inputs become bit 7 of low and high address.
// - 64K mode: bank-3 strobe pin becomes single bank select, two banks.
// - Test cycle zeroes refresh address counter then performs a write.
// - Eight-bit multiplexer selects row, column or refresh address.
// - Eight-bit refresh counter over 256 rows, refresh every 15.6 us.
// - A started memory cycle always runs to completion.
`timescale 1ns/1ns
`default_nettype none
module dca_ctrl
   import dca_pkg::*;
#(
   parameter int REFR_CYCLES = DCA_REFR_CYCLES
)
(
   // Clock and reset
   input  wire logic              clk,
   input  wire logic              rstn,
   // Configuration
   input  wire logic              advanced_read_mode,
   input  wire logic              density_select,
   // Host command pins
   input  wire dca_cmd_type       cmd,
   input  wire logic              ext_refr_req,
   // Address inputs, bits 6:0
   input  wire logic [6:0]        low_half_addr_in,
   input  wire logic [6:0]        high_half_addr_in,
   input  wire logic              bank_sel_lo,
   input  wire logic              bank_sel_hi,
   input  wire logic              row_strobe_bank3_in,
   // Acknowledges
   output logic                   early_sys_ack_n,
   output logic                   late_xfer_ack_n,
   // RAM side
   output dca_ram_type            ram,
   output logic [6:0]             ram_addr_out,
   output logic                   ram_addr_msb_out,
   output logic                   row_strobe_bank3_oe_n,
   output logic [7:0]             refr_addr
);

   // Pin synchronisers, three stages; change counts when stages 2 and 3 agree
   localparam int NSYNC = 5;
   logic [NSYNC-1:0] s1_reg, s2_reg, s3_reg, in_reg;
   logic [NSYNC-1:0] pin_vec;
   assign pin_vec = {cmd.rd_n, cmd.wr_n, cmd.port_chip_sel_n, cmd.addr_latch_n, cmd.read_status_bit};

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s1_reg <= 5'h1e;
         s2_reg <= 5'h1e;
         s3_reg <= 5'h1e;
         in_reg <= 5'h1e;
      end
      else
      begin
         s1_reg <= pin_vec;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         for (int i = 0; i < NSYNC; i++)
            if (s2_reg[i] == s3_reg[i])
               in_reg[i] <= s3_reg[i];
      end
   end

   // Filtered pins back to active-high meaning
   logic rd, wr, cs, ale, st1;
   always_comb
   begin
      rd  = !in_reg[4];
      wr  = !in_reg[3];
      cs  = !in_reg[2];
      ale = !in_reg[1];
      st1 = in_reg[0];
   end

   // Density strap caught after reset release; static thereafter
   logic mode64_reg, strap_done_reg;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mode64_reg     <= 1'b0;
         strap_done_reg <= 1'b0;
      end
      else if (!strap_done_reg)
      begin
         mode64_reg     <= !density_select;
         strap_done_reg <= 1'b1;
      end
   end

   logic ale_d_reg;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         ale_d_reg <= 1'b0;
      else
         ale_d_reg <= ale;
   end

   logic ale_fall;
   assign ale_fall = ale && !ale_d_reg;

   // Memory request: advanced read uses latch strobe with status for reads
   logic test_req, mem_req, rd_req;
   // Advanced reads start on the strobe edge only, not on the level
   always_comb
   begin
      rd_req   = advanced_read_mode ? (ale_fall && st1) : rd;
      test_req = rd && wr && cs;
      mem_req  = cs && (rd_req || wr);
   end

   // Refresh timer
   logic [15:0] refr_tmr_reg;
   logic        refr_pend_reg;
   dca_state_type state_reg;
   logic [DCA_CYC_LEN-1:0] step_reg;
   logic        delay_flag_reg, test_reg, wr_cyc_reg, ack_reg, late_xfer_ack_n_reg;
   logic        start_mem, start_ref, eoc;

   assign eoc       = (state_reg != DCA_IDLE) && step_reg[DCA_CYC_LEN-1];
   assign start_mem = (state_reg == DCA_IDLE) && mem_req && !ack_reg;
   assign start_ref = (state_reg == DCA_IDLE) && !start_mem && refr_pend_reg;

   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         refr_tmr_reg  <= 16'h0000;
         refr_pend_reg <= 1'b0;
      end
      else
      begin
         if (start_ref)
            refr_tmr_reg <= 16'h0000;
         else if (refr_tmr_reg < 16'(REFR_CYCLES - 1))
            refr_tmr_reg <= refr_tmr_reg + 16'h0001;
         if (start_ref)
            refr_pend_reg <= 1'b0;
         else if (ext_refr_req && !advanced_read_mode || refr_tmr_reg == 16'(REFR_CYCLES - 1))
            refr_pend_reg <= 1'b1;
      end
   end

   // Arbiter and travelling-ones cycle timing; no abort path once started
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_reg  <= DCA_IDLE;
         step_reg   <= '0;
         test_reg   <= 1'b0;
         wr_cyc_reg <= 1'b0;
      end
      else
      begin
         unique case (state_reg)
            DCA_IDLE:
            begin
               if (start_mem)
               begin
                  state_reg  <= DCA_MEM;
                  step_reg   <= 8'h01;
                  test_reg   <= test_req;
                  wr_cyc_reg <= wr;
               end
               else if (start_ref)
               begin
                  state_reg <= DCA_REF;
                  step_reg  <= 8'h01 << (DCA_CYC_LEN - DCA_REFR_LEN);
               end
            end
            DCA_MEM, DCA_REF:
            begin
               step_reg <= step_reg << 1;
               if (eoc)
               begin
                  state_reg <= DCA_IDLE;
                  step_reg  <= '0;
                  test_reg  <= 1'b0;
               end
            end
         endcase
      end
   end

   // Refresh address counter
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         refr_addr <= DCA_REFR_ADDR_RST;
      else if (start_mem && test_req)
         refr_addr <= DCA_REFR_ADDR_RST;
      else if (state_reg == DCA_REF && eoc)
         refr_addr <= refr_addr + 8'h01;
   end

   // Delayed early-acknowledge flag; a new set wins over the end-of-cycle clear
   logic in_refr, dly_set;
   // Chip select ignored here, so unselected traffic also delays the next ack
   always_comb
   begin
      in_refr = (state_reg == DCA_REF);
      dly_set = in_refr && ((rd || wr) || (advanced_read_mode && ale_fall && st1));
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         delay_flag_reg <= 1'b0;
      else if (dly_set)
         delay_flag_reg <= 1'b1;
      else if (state_reg == DCA_MEM && eoc)
         delay_flag_reg <= 1'b0;
   end

   // Acknowledges: set by cycle timing, dropped only by host
   logic ack_drop, early_sys_ack_n_step;
   // Delayed timing gives the host extra wait states behind a refresh
   always_comb
   begin
      ack_drop = !(rd || wr);
      if (advanced_read_mode && ale_fall)
         ack_drop = 1'b1;
      if (delay_flag_reg)
         early_sys_ack_n_step = step_reg[DCA_EARLY_SYS_ACK_N_DELAYED];
      else
         early_sys_ack_n_step = step_reg[DCA_EARLY_SYS_ACK_N_NORMAL];
   end
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ack_reg  <= 1'b0;
         late_xfer_ack_n_reg <= 1'b0;
      end
      else if (ack_drop)
      begin
         ack_reg  <= 1'b0;
         late_xfer_ack_n_reg <= 1'b0;
      end
      else if (state_reg == DCA_MEM)
      begin
         if (early_sys_ack_n_step)
            ack_reg <= 1'b1;
         if (step_reg[DCA_LATE_XFER_ACK_N_STEP])
            late_xfer_ack_n_reg <= 1'b1;
      end
   end

   // Host waits on these
   assign early_sys_ack_n = !ack_reg;
   assign late_xfer_ack_n = !late_xfer_ack_n_reg;

   // Address mux and strobes
   logic [1:0]  bank;
   logic [7:0]  row_addr, col_addr, mux_addr;
   dca_mux_type mux_sel;
   logic        ras_act, cas_act;

   // 64K mode has one bank-select pin, so only banks 0 and 1 exist
   always_comb
   begin
      if (mode64_reg)
         bank = {1'b0, row_strobe_bank3_in};
      else
         bank = {bank_sel_hi, bank_sel_lo};
   end
   assign row_addr = {mode64_reg & bank_sel_lo, low_half_addr_in};
   assign col_addr = {mode64_reg & bank_sel_hi, high_half_addr_in};
   assign ras_act  = (state_reg != DCA_IDLE) && (step_reg != '0);
   assign cas_act  = (state_reg == DCA_MEM) && (step_reg >= (8'h01 << DCA_CAS_ON));
   // Refresh address wins; column follows row within a memory cycle
   always_comb
   begin
      if (in_refr)
         mux_sel = DCA_MUX_REFR;
      else if (cas_act)
         mux_sel = DCA_MUX_COL;
      else
         mux_sel = DCA_MUX_ROW;
   end

   always_comb
   begin
      unique case (mux_sel)
         DCA_MUX_ROW:  mux_addr = row_addr;
         DCA_MUX_COL:  mux_addr = col_addr;
         DCA_MUX_REFR: mux_addr = refr_addr;
         default:      mux_addr = row_addr;
      endcase
   end

   dca_ram_type ram_next;
   always_comb
   begin
      ram_next.ras_n = 4'hf;
      if (ras_act)
         ram_next.ras_n = in_refr ? 4'h0 : ~(4'h1 << bank);
      ram_next.cas_n = !cas_act;
      ram_next.we_n  = !(cas_act && (wr_cyc_reg || test_reg));
   end

   // Strobes registered so the RAM pins stay free of decode glitches
   logic msb_reg;
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         ram          <= '{ras_n: 4'hf, cas_n: 1'b1, we_n: 1'b1};
         ram_addr_out <= 7'h00;
         msb_reg      <= 1'b1;
      end
      else
      begin
         ram          <= ram_next;
         ram_addr_out <= mux_addr[6:0];
         msb_reg      <= mode64_reg ? mux_addr[7] : ram_next.ras_n[2];
      end
   end

   assign ram_addr_msb_out      = msb_reg;
   assign row_strobe_bank3_oe_n = mode64_reg;

endmodule
`default_nettype wire

// ### dca_ctrl_props.sv
`timescale 1ns/1ns
`default_nettype none
module dca_ctrl_props
   import dca_pkg::*;
#(
   parameter int REFR_CYCLES = DCA_REFR_CYCLES
)
(
   // Clock and configuration
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic        advanced_read_mode,
   input wire logic        density_select,
   // Pins
   input wire dca_cmd_type cmd,
   input wire logic        early_sys_ack_n,
   input wire logic        late_xfer_ack_n,
   input wire dca_ram_type ram,
   input wire logic        ram_addr_msb_out,
   input wire logic        row_strobe_bank3_oe_n,
   input wire logic [7:0]  refr_addr
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rstn);
   logic cas_seen_reg;
   // Column strobe seen since last late ack
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         cas_seen_reg <= 1'b0;
      else if (!ram.cas_n)
         cas_seen_reg <= 1'b1;
      else if (!late_xfer_ack_n)
         cas_seen_reg <= 1'b0;
   end
   property p_late_after_cas;
      $fell(late_xfer_ack_n) |-> cas_seen_reg;
   endproperty
   a_late_after_cas: assert property (p_late_after_cas) else $error("late ack before ram access");
   property p_early_first;
      $fell(late_xfer_ack_n) |-> !$past(early_sys_ack_n);
   endproperty
   a_early_first: assert property (p_early_first) else $error("late ack before early ack");
   property p_ack_gap;
      $fell(early_sys_ack_n) |-> late_xfer_ack_n ##[1:4] !late_xfer_ack_n;
   endproperty
   a_ack_gap: assert property (p_ack_gap) else $error("late ack not after early ack");
   property p_ack_hold;
      !advanced_read_mode && !late_xfer_ack_n && !cmd.rd_n && !$past(cmd.rd_n, 6) |=> !late_xfer_ack_n;
   endproperty
   a_ack_hold: assert property (p_ack_hold) else $error("ack dropped under command");
   property p_ack_release;
      (cmd.rd_n && cmd.wr_n && !advanced_read_mode) [*8] |-> early_sys_ack_n && late_xfer_ack_n;
   endproperty
   a_ack_release: assert property (p_ack_release) else $error("ack held without command");
   property p_ale_drop;
      advanced_read_mode && !early_sys_ack_n && $fell(cmd.addr_latch_n) |-> ##[1:6] (early_sys_ack_n && late_xfer_ack_n);
   endproperty
   a_ale_drop: assert property (p_ale_drop) else $error("ack kept after latch strobe");
   property p_bank3_dir;
      $past(rstn, 3) |-> row_strobe_bank3_oe_n == !density_select;
   endproperty
   a_bank3_dir: assert property (p_bank3_dir) else $error("bank3 pin direction wrong");
   property p_msb_row_strobe_bank2_n;
      density_select && $past(rstn, 3) |-> ram_addr_msb_out == ram.ras_n[2];
   endproperty
   a_msb_row_strobe_bank2_n: assert property (p_msb_row_strobe_bank2_n) else $error("bank2 strobe pin wrong");
   property p_refr_step;
      $changed(refr_addr) |-> refr_addr == $past(refr_addr) + 8'h01 || refr_addr == 8'h00;
   endproperty
   a_refr_step: assert property (p_refr_step) else $error("refresh counter skipped");
   cover property ($fell(early_sys_ack_n) ##1 !late_xfer_ack_n);
   cover property (!cmd.rd_n && !cmd.wr_n && !cmd.port_chip_sel_n);
   cover property (advanced_read_mode && $fell(cmd.addr_latch_n));
endmodule
`default_nettype wire

// ### dca_host.sv
`timescale 1ns/1ns
`default_nettype none
module dca_host
   import dca_pkg::*;
(
   // Clock and acknowledges
   input  wire logic       clk,
   input  wire logic       early_sys_ack_n,
   input  wire logic       late_xfer_ack_n,
   // Command pins
   output var dca_cmd_type cmd
);
   initial cmd = 5'h1e;
   task automatic put(input dca_cmd_type c);
      cmd <= c;
   endtask
   // Wait states until acked, then hold command; bounded since no ack may come
   task automatic access(input dca_cmd_type c, input dca_cmd_type rel, output int e_lat, output int l_lat,
                         output bit held);
      e_lat = -1;
      l_lat = -1;
      held = 1'b1;
      cmd <= c;
      for (int n = 0; n < 40 && !(l_lat >= 0 && n > l_lat + 3); n++)
      begin
         @(posedge clk);
         if (e_lat < 0 && early_sys_ack_n === 1'b0)
            e_lat = n;
         if (l_lat < 0 && late_xfer_ack_n === 1'b0)
            l_lat = n;
         if (l_lat >= 0 && {early_sys_ack_n, late_xfer_ack_n} !== 2'b00)
            held = 1'b0;
      end
      cmd <= rel;
   endtask
endmodule
`default_nettype wire

// ### tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top
   import dca_pkg::*;
;
   localparam int NRM = DCA_LATE_XFER_ACK_N_STEP - DCA_EARLY_SYS_ACK_N_NORMAL;
   localparam int DLY = DCA_LATE_XFER_ACK_N_STEP - DCA_EARLY_SYS_ACK_N_DELAYED;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        adv = 1'b0;
   logic        dens = 1'b1;
   logic        refr_req = 1'b0;
   logic [1:0]  bsel = 2'b00;
   logic        b3 = 1'b0;
   logic        mon_clr = 1'b1;
   logic [3:0]  ras_seen;
   logic        msb0_seen;
   logic        we_seen;
   dca_cmd_type cmd;
   dca_ram_type ram;
   logic        early_n;
   logic        late_n;
   logic        msb;
   logic        oe_n;
   logic [7:0]  refr_addr;
   int          fail_count = 0;
   int          num_checks = 0;
   int          cycles = 0;
   int          e;
   int          l;
   bit          h;
   always #10 clk = ~clk;
   // Long refresh interval keeps stray refreshes out of latency checks
   dca_ctrl #(.REFR_CYCLES(4000)) DUT
   (
      .clk(clk), .rstn(rstn), .advanced_read_mode(adv), .density_select(dens), .cmd(cmd),
      .ext_refr_req(refr_req), .low_half_addr_in(7'h00), .high_half_addr_in(7'h00), .bank_sel_lo(bsel[0]),
      .bank_sel_hi(bsel[1]), .row_strobe_bank3_in(b3), .early_sys_ack_n(early_n), .late_xfer_ack_n(late_n),
      .ram(ram), .ram_addr_out(), .ram_addr_msb_out(msb), .row_strobe_bank3_oe_n(oe_n), .refr_addr(refr_addr)
   );
   dca_host host
   (
      .clk(clk), .early_sys_ack_n(early_n), .late_xfer_ack_n(late_n), .cmd(cmd)
   );
   always @(posedge clk)
   begin
      cycles <= cycles + 1;
      ras_seen <= mon_clr ? 4'h0 : ras_seen | ~ram.ras_n;
      msb0_seen <= !mon_clr && (msb0_seen || !msb);
      we_seen <= !mon_clr && (we_seen || !ram.we_n);
      if (cycles == 20000)
      begin
         fail_count++;
         conclude();
      end
   end
   task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("mismatch %s expected %0h seen %0h", name, exp, seen);
      end
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   task automatic do_reset(input logic d, input logic a);
      rstn <= 1'b0;
      dens <= d;
      adv <= a;
      repeat (16) @(posedge clk);
      rstn <= 1'b1;
      repeat (2) @(posedge clk);
      check("acks_rst", {early_n, late_n, refr_addr}, 10'h300);
   endtask
   task automatic pulse_refr();
      refr_req <= 1'b1;
      @(posedge clk);
      refr_req <= 1'b0;
   endtask
   task automatic run(input dca_cmd_type c, input int gap);
      mon_clr <= 1'b1;
      @(posedge clk);
      mon_clr <= 1'b0;
      host.access(c, 5'h1e, e, l, h);
      check("ack_hold", h, 1'b1);
      check("ack_gap", l - e, gap);
      repeat (8) @(posedge clk);
      check("ack_off", {early_n, late_n}, 2'b11);
   endtask
   initial
   begin
      do_reset(1'b1, 1'b0);
      run(5'h0a, NRM);
      run(5'h12, NRM);
      pulse_refr();
      run(5'h0a, DLY);
      pulse_refr();
      run(5'h0e, 0);
      run(5'h0a, DLY);
      run(5'h0a, NRM);
      check("refr_cnt", refr_addr, 8'h02);
      run(5'h02, NRM);
      check("test_zero", {we_seen, refr_addr}, 9'h100);
      for (int m = 0; m < 2; m++)
      begin
         do_reset(m[0], 1'b0);
         bsel <= 2'b10;
         b3 <= 1'b1;
         run(5'h0a, NRM);
         check("bank3_dir", oe_n, !m[0]);
         check("ras_used", ras_seen, (m == 1) ? 4'h4 : 4'h2);
         check("msb_low", msb0_seen, 1'b1);
      end
      do_reset(1'b1, 1'b1);
      host.access(5'h09, 5'h0b, e, l, h);
      check("adv_gap", {h, 8'(l - e)}, {1'b1, 8'(NRM)});
      // Strobe must stand high long enough to pass the pin filter
      repeat (4) @(posedge clk);
      host.put(5'h08);
      repeat (6) @(posedge clk);
      check("ale_drop", {early_n, late_n}, 2'b11);
      host.put(5'h1e);
      repeat (16) @(posedge clk);
      conclude();
   end
endmodule
bind dca_ctrl dca_ctrl_props #(.REFR_CYCLES(REFR_CYCLES)) u_props
(
   .clk(clk), .rstn(rstn), .advanced_read_mode(advanced_read_mode), .density_select(density_select),
   .cmd(cmd), .early_sys_ack_n(early_sys_ack_n), .late_xfer_ack_n(late_xfer_ack_n), .ram(ram),
   .ram_addr_msb_out(ram_addr_msb_out), .row_strobe_bank3_oe_n(row_strobe_bank3_oe_n), .refr_addr(refr_addr)
);
`default_nettype wire
